// ---- iqt_core.sv ----
// Core end: two-stage instruction queue with holding latch, bus phase clock and status outputs.
// Assumes a user-side fetch/execute controller supplies requests; the tracker joins via iqt_if.
`timescale 1ns/100ps
module iqt_core (
    input wire logic sys_clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    iqt_if.core link, // Tracking pins.
    input wire logic [1:0] move_req, // Movement requested for this bus cycle.
    input wire logic [1:0] start_req, // Start requested for next bus cycle.
    input wire logic exec_done, // Current instruction has finished.
    input wire logic [15:0] fetch_addr, // Program fetch address.
    input wire logic [15:0] fetch_data, // Program data from the bus input buffer.
    output logic [7:0] opcode, // Opcode of the instruction started.
    output logic opcode_valid, // Pulse with opcode.
    output logic [15:0] stage1, // First queue stage.
    output logic [15:0] stage2, // Second queue stage.
    output logic move_ack, // Pulse when a movement is taken.
    output logic start_ack // Pulse when a start is taken.
);
    logic [3:0] div_cnt;
    logic phase;
    logic [15:0] hold_latch;
    logic [1:0] status;
    logic [1:0] pend_move;
    logic [1:0] queue_bytes;
    logic busy;
    logic [15:0] bus_addr;
    logic [15:0] bus_data;
    wire half_end = (div_cnt == iqt_pkg::PHASE_HALF - 4'h1);
    wire phase_rise = half_end & ~phase;
    wire phase_fall = half_end & phase;
    wire adv = (pend_move == iqt_pkg::MOVE_ADV_BUS) | (pend_move == iqt_pkg::MOVE_ADV_LATCH);
    wire [15:0] stage1_src = (pend_move == iqt_pkg::MOVE_ADV_LATCH) ? hold_latch : bus_data;
    // An instruction start is only allowed with enough code in the queue and no instruction running.
    wire start_ok = (queue_bytes == 2'h2) & ~busy;
    wire is_exec = (start_req == iqt_pkg::START_EVEN) | (start_req == iqt_pkg::START_ODD);
    wire take_start = phase_fall & (start_req != iqt_pkg::START_NONE) & (start_ok | ~is_exec);
    wire [7:0] sel_op = (start_req == iqt_pkg::START_EVEN) ? stage2[15:8] : stage2[7:0];
    wire [1:0] new_bytes = (queue_bytes == 2'h2) ? 2'h2 : queue_bytes + 2'h1;
    assign move_ack = phase_fall;
    assign start_ack = take_start;
    assign link.bus_phase_clock = phase;
    assign link.queue_status_out = status;
    assign link.addr = bus_addr;
    assign link.data = bus_data;
    assign link.rd_wr = 1'b1;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_cnt <= 4'h0;
            phase <= 1'b0;
        end else if (half_end) begin
            div_cnt <= 4'h0;
            phase <= ~phase;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    // Bus cycle begins at the falling edge: capture fetch and the movement for it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_addr <= iqt_pkg::ADDR_RESET;
            bus_data <= iqt_pkg::WORD_RESET;
            pend_move <= iqt_pkg::MOVE_NONE;
        end else if (phase_fall) begin
            bus_addr <= fetch_addr;
            bus_data <= fetch_data;
            pend_move <= move_req;
        end
    end
    // Queue movement is applied at the rising edge, describing the previous falling-edge data.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_latch <= iqt_pkg::WORD_RESET;
            stage1 <= iqt_pkg::WORD_RESET;
            stage2 <= iqt_pkg::WORD_RESET;
            queue_bytes <= 2'h0;
        end else if (phase_rise) begin
            if (pend_move == iqt_pkg::MOVE_LATCH_BUS) begin
                hold_latch <= bus_data;
            end
            if (adv) begin
                stage2 <= stage1;
                stage1 <= stage1_src;
                queue_bytes <= new_bytes;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy <= 1'b0;
            opcode <= iqt_pkg::BYTE_RESET;
            opcode_valid <= 1'b0;
        end else begin
            opcode_valid <= take_start & is_exec;
            if (take_start & is_exec) begin
                opcode <= sel_op;
                busy <= 1'b1;
            end else if (exec_done) begin
                busy <= 1'b0;
            end
        end
    end
    // Status pins: start code during the low phase, movement code during the high phase.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status <= iqt_pkg::MOVE_NONE;
        end else if (phase_fall) begin
            status <= take_start ? start_req : iqt_pkg::START_NONE;
        end else if (half_end & ~phase) begin
            status <= pend_move;
        end
    end
endmodule

// ---- iqt_edge.sv ----
// Two-flop synchroniser with rise and fall pulses for the bus phase clock.
// Assumes the input may come from a pin.
`timescale 1ns/100ps
module iqt_edge (
    input wire logic sys_clk, // System clock.
    input wire logic srst, // Synchronous reset.
    input wire logic din, // Raw level.
    output logic level, // Synchronised level.
    output logic rise, // Rising edge pulse.
    output logic fall // Falling edge pulse.
);
    logic meta;
    logic sync;
    logic prev;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= din;
            sync <= meta;
            prev <= sync;
        end
    end
    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

// ---- iqt_if.sv ----
// Interface joining the core queue end and the external tracker end.
// Assumes one system clock shared by both parties.
`timescale 1ns/100ps
interface iqt_if;
    logic bus_phase_clock;
    logic [1:0] queue_status_out;
    logic [15:0] addr;
    logic [15:0] data;
    logic rd_wr;
    modport core (output bus_phase_clock, output queue_status_out, output addr, output data, output rd_wr);
    modport tracker (input bus_phase_clock, input queue_status_out, input addr, input data, input rd_wr);
endinterface

// ---- iqt_pkg.sv ----
// Package for the instruction queue tracking block: status encodings and widths.
// Assumes both ends and the interface refer to these names with full package scope.
package iqt_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int MIN_QUEUE_BYTES = 3;
    // Data-movement codes, valid at the rising phase edge.
    localparam logic [1:0] MOVE_NONE = 2'h0;
    localparam logic [1:0] MOVE_LATCH_BUS = 2'h1;
    localparam logic [1:0] MOVE_ADV_BUS = 2'h2;
    localparam logic [1:0] MOVE_ADV_LATCH = 2'h3;
    // Execution-start codes, valid at the falling phase edge.
    localparam logic [1:0] START_NONE = 2'h0;
    localparam logic [1:0] START_INT = 2'h1;
    localparam logic [1:0] START_EVEN = 2'h2;
    localparam logic [1:0] START_ODD = 2'h3;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    // Half-period of the bus phase clock in system clocks.
    localparam logic [3:0] PHASE_HALF = 4'h2;
endpackage

// ---- iqt_props.sv ----
// Checker for the tracking pins between the core end and the tracker end.
// Assumes the pins share the system clock and its synchronous reset.
`timescale 1ns/100ps
module iqt_props (
    input wire logic sys_clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic bus_phase_clock, // Phase clock pin.
    input wire logic [1:0] queue_status_out, // Status pins.
    input wire logic [15:0] addr, // Bus address.
    input wire logic [15:0] data, // Bus data.
    input wire logic rd_wr // Read or write.
);
    logic ph_q;
    logic rst_q;
    logic [1:0] adv_cnt;
    wire logic rise_pt = bus_phase_clock && !ph_q;
    wire logic fall_pt = !bus_phase_clock && ph_q;
    wire logic adv_seen = rise_pt && queue_status_out[1] && (adv_cnt != 2'h3);
    // Advances shown since reset, saturating, so starts can be judged against queue fill.
    always_ff @(posedge sys_clk) begin
        ph_q <= srst ? 1'b0 : bus_phase_clock;
        rst_q <= srst;
        adv_cnt <= srst ? 2'h0 : adv_cnt + {1'b0, adv_seen};
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_high_two_cycles: assert property ($rose(bus_phase_clock) |-> ##1 bus_phase_clock ##1 !bus_phase_clock)
        else $error("phase high time wrong");
    chk_low_two_cycles: assert property ($fell(bus_phase_clock) |-> ##1 !bus_phase_clock ##1 bus_phase_clock)
        else $error("phase low time wrong");
    chk_reset_idle: assert property (disable iff (1'b0) srst |=> queue_status_out == 2'h0 && !bus_phase_clock)
        else $error("status not idle in reset");
    chk_move_code_hold: assert property (bus_phase_clock && ph_q |-> $stable(queue_status_out))
        else $error("status moved in high phase");
    chk_start_code_hold: assert property (!bus_phase_clock && !ph_q |-> $stable(queue_status_out))
        else $error("status moved in low phase");
    // A reset clears the bus outside any bus cycle, so the cycle just after it is not judged.
    chk_bus_at_fall: assert property (!fall_pt && !rst_q |-> $stable(addr) && $stable(data))
        else $error("bus changed away from fall");
    chk_read_only: assert property (rd_wr)
        else $error("bus not a read");
    chk_queue_ready: assert property (fall_pt && queue_status_out[1] |-> adv_cnt >= 2'h2)
        else $error("start before queue filled");
    cover property (fall_pt && queue_status_out == iqt_pkg::START_EVEN);
    cover property (fall_pt && queue_status_out == iqt_pkg::START_ODD);
    cover property (fall_pt && queue_status_out == iqt_pkg::START_INT);
    cover property (rise_pt && queue_status_out == iqt_pkg::MOVE_ADV_LATCH);
endmodule

// ---- iqt_tracker.sv ----
// Tracker end: rebuilds the queue with addresses from the status pins and bus.
// Assumes pins come from the core end and are synchronised here.
`timescale 1ns/100ps
module iqt_tracker (
    input wire logic sys_clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    iqt_if.tracker link, // Tracking pins.
    output logic [15:0] trk_stage1, // Rebuilt first stage data.
    output logic [15:0] trk_stage1_addr, // Its address.
    output logic [15:0] trk_stage2, // Rebuilt second stage data.
    output logic [15:0] trk_stage2_addr, // Its address.
    output logic [7:0] trk_opcode, // Opcode seen starting.
    output logic [15:0] trk_opcode_addr, // Address of that opcode.
    output logic trk_start, // Pulse on an instruction start.
    output logic trk_int // Pulse on an interrupt start.
);
    logic clk_lvl;
    logic clk_rise;
    logic clk_fall;
    logic [1:0] st_m;
    logic [1:0] st_s;
    logic [31:0] bus_m;
    logic [31:0] bus_s;
    logic [15:0] cyc_addr;
    logic [15:0] cyc_data;
    logic [15:0] lat_data;
    logic [15:0] lat_addr;
    iqt_edge u_edge (
        .sys_clk(sys_clk),
        .srst(srst),
        .din(link.bus_phase_clock),
        .level(clk_lvl),
        .rise(clk_rise),
        .fall(clk_fall)
    );
    // Status and bus pass two flops so they align with the synchronised clock.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_m <= iqt_pkg::MOVE_NONE;
            st_s <= iqt_pkg::MOVE_NONE;
            bus_m <= 32'h0000_0000;
            bus_s <= 32'h0000_0000;
        end else begin
            st_m <= link.queue_status_out;
            st_s <= st_m;
            bus_m <= {link.addr, link.data};
            bus_s <= bus_m;
        end
    end
    wire even_start = clk_fall & (st_s == iqt_pkg::START_EVEN);
    wire odd_start = clk_fall & (st_s == iqt_pkg::START_ODD);
    wire [15:0] adv_src = (st_s == iqt_pkg::MOVE_ADV_LATCH) ? lat_data : cyc_data;
    wire [15:0] adv_addr = (st_s == iqt_pkg::MOVE_ADV_LATCH) ? lat_addr : cyc_addr;
    wire adv = clk_rise & st_s[1];
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cyc_addr <= iqt_pkg::ADDR_RESET;
            cyc_data <= iqt_pkg::WORD_RESET;
            lat_data <= iqt_pkg::WORD_RESET;
            lat_addr <= iqt_pkg::ADDR_RESET;
            trk_stage1 <= iqt_pkg::WORD_RESET;
            trk_stage1_addr <= iqt_pkg::ADDR_RESET;
            trk_stage2 <= iqt_pkg::WORD_RESET;
            trk_stage2_addr <= iqt_pkg::ADDR_RESET;
            trk_opcode <= iqt_pkg::BYTE_RESET;
            trk_opcode_addr <= iqt_pkg::ADDR_RESET;
            trk_start <= 1'b0;
            trk_int <= 1'b0;
        end else begin
            trk_start <= even_start | odd_start;
            trk_int <= clk_fall & (st_s == iqt_pkg::START_INT);
            if (clk_fall) begin
                cyc_addr <= bus_s[31:16];
                cyc_data <= bus_s[15:0];
            end
            if (clk_rise & (st_s == iqt_pkg::MOVE_LATCH_BUS)) begin
                lat_data <= cyc_data;
                lat_addr <= cyc_addr;
            end
            if (adv) begin
                trk_stage2 <= trk_stage1;
                trk_stage2_addr <= trk_stage1_addr;
                trk_stage1 <= adv_src;
                trk_stage1_addr <= adv_addr;
            end
            if (even_start) begin
                trk_opcode <= trk_stage2[15:8];
                trk_opcode_addr <= trk_stage2_addr;
            end else if (odd_start) begin
                trk_opcode <= trk_stage2[7:0];
                trk_opcode_addr <= trk_stage2_addr + 16'h0001;
            end
        end
    end
endmodule

// ---- test_instruction_queue_tracking.sv ----
// Testbench joining the core end and tracker end through the tracking interface.
// Assumes the hand-over timing: requests taken at the phase fall, answers within a few cycles.
`timescale 1ns/100ps
module test_instruction_queue_tracking;
    typedef struct {logic [1:0] code; logic [15:0] d; logic [15:0] s1; logic [15:0] s2;} iqt_row_s;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] move_req = 2'h0;
    logic [1:0] start_req = 2'h0;
    logic exec_done = 1'b0;
    logic [15:0] fetch_data = 16'h0000;
    logic [7:0] opcode, trk_opcode;
    logic [15:0] stage1, stage2, trk_stage1, trk_stage1_addr, trk_stage2, trk_stage2_addr, trk_opcode_addr;
    logic opcode_valid, move_ack, start_ack, trk_start, trk_int;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic seen;
    // Addresses differ from the data, so a swap of the two in the tracker shows up.
    wire logic [15:0] fetch_addr = {fetch_data[7:0], fetch_data[15:8]};
    wire logic [3:0] evs = {trk_start | trk_int, opcode_valid, start_ack, move_ack};
    iqt_row_s rows [5] = '{'{iqt_pkg::MOVE_ADV_BUS, 16'h1A2B, 16'h1A2B, 16'h0000},
        '{iqt_pkg::MOVE_LATCH_BUS, 16'h3C4D, 16'h1A2B, 16'h0000},
        '{iqt_pkg::MOVE_ADV_BUS, 16'h5E6F, 16'h5E6F, 16'h1A2B},
        '{iqt_pkg::MOVE_ADV_LATCH, 16'h7081, 16'h3C4D, 16'h5E6F},
        '{iqt_pkg::MOVE_NONE, 16'h9AB0, 16'h3C4D, 16'h5E6F}};
    iqt_if link_if ();
    iqt_core u_iqt_core (.sys_clk(sys_clk), .srst(srst), .link(link_if), .move_req(move_req),
        .start_req(start_req), .exec_done(exec_done), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
        .opcode(opcode), .opcode_valid(opcode_valid), .stage1(stage1), .stage2(stage2),
        .move_ack(move_ack), .start_ack(start_ack));
    iqt_tracker u_iqt_tracker (.sys_clk(sys_clk), .srst(srst), .link(link_if), .trk_stage1(trk_stage1),
        .trk_stage1_addr(trk_stage1_addr), .trk_stage2(trk_stage2), .trk_stage2_addr(trk_stage2_addr),
        .trk_opcode(trk_opcode), .trk_opcode_addr(trk_opcode_addr), .trk_start(trk_start), .trk_int(trk_int));
    iqt_props u_iqt_props (.sys_clk(sys_clk), .srst(srst), .bus_phase_clock(link_if.bus_phase_clock),
        .queue_status_out(link_if.queue_status_out), .addr(link_if.addr), .data(link_if.data),
        .rd_wr(link_if.rd_wr));
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    // Waits up to twelve cycles for one event bit; sampled mid-cycle so pulses are settled.
    task automatic wait_ev(input int b, output logic hit);
        int i;
        hit = 1'b0;
        for (i = 0; i < 12 && !hit; i++) begin
            @(negedge sys_clk);
            hit = evs[b];
        end
    endtask
    task automatic do_move(input logic [1:0] code, input logic [15:0] d);
        move_req = code;
        fetch_data = d;
        wait_ev(0, seen);
        @(posedge sys_clk) #1;
        move_req = iqt_pkg::MOVE_NONE;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    task automatic do_start(input logic [1:0] code, input logic ok, input logic ed, input logic [15:0] waddr);
        start_req = code;
        exec_done = ed;
        wait_ev(1, seen);
        check({15'h0000, seen}, {15'h0000, ok});
        @(posedge sys_clk) #1;
        start_req = iqt_pkg::START_NONE;
        exec_done = 1'b0;
        if (ok && code != iqt_pkg::START_INT) begin
            wait_ev(2, seen);
            check({8'h00, opcode}, code[0] ? {8'h00, waddr[7:0]} : {8'h00, waddr[15:8]});
            wait_ev(3, seen);
            check({15'h0000, trk_start}, 16'h0001);
            check({8'h00, trk_opcode}, code[0] ? {8'h00, waddr[7:0]} : {8'h00, waddr[15:8]});
            check(trk_opcode_addr, {waddr[7:0], waddr[15:8]} + {15'h0000, code[0]});
        end else if (ok) begin
            wait_ev(3, seen);
            check({15'h0000, trk_int}, 16'h0001);
            check({15'h0000, trk_start}, 16'h0000);
        end
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 srst = 1'b0;
        check({14'h0000, link_if.queue_status_out}, 16'h0000);
        check(stage1, 16'h0000);
        do_start(iqt_pkg::START_EVEN, 1'b0, 1'b1, 16'h0000);
        foreach (rows[k]) begin
            do_move(rows[k].code, rows[k].d);
            check(stage1, rows[k].s1);
            check(stage2, rows[k].s2);
            check(trk_stage1, rows[k].s1);
            check(trk_stage1_addr, {rows[k].s1[7:0], rows[k].s1[15:8]});
            check(trk_stage2, rows[k].s2);
            check(trk_stage2_addr, {rows[k].s2[7:0], rows[k].s2[15:8]});
        end
        do_start(iqt_pkg::START_EVEN, 1'b1, 1'b1, 16'h5E6F);
        do_start(iqt_pkg::START_ODD, 1'b1, 1'b1, 16'h5E6F);
        do_start(iqt_pkg::START_EVEN, 1'b0, 1'b0, 16'h5E6F);
        do_start(iqt_pkg::START_INT, 1'b1, 1'b0, 16'h5E6F);
        srst = 1'b1;
        @(posedge sys_clk) #1;
        srst = 1'b0;
        check(stage2, 16'h0000);
        check({14'h0000, link_if.queue_status_out}, 16'h0000);
        check(trk_stage2, 16'h0000);
        // The queue is empty again after reset, so an instruction start must be refused.
        do_start(iqt_pkg::START_EVEN, 1'b0, 1'b1, 16'h0000);
        test_done();
    end
endmodule
